/* pmw_pkg.sv */
// Package for the PHY management write port: offsets, fields, states and carriers
// Overview of operation
// RULE_01: Only loader reaches registers; host accesses ignored
// RULE_02: Data register low 16 bits, write-only, reset zero
// RULE_03: Loader writes data before control register
// RULE_04: Control write launches cycle with current data
// RULE_05: Control bits 15:11 select target PHY
// RULE_06: Control bits 10:6 select register index
// RULE_07: Loader writes reserved bit 1 as one
// RULE_08: Data at 0A4h, control at 0A8h, paired
// RULE_09: Write-only pair, no read-back path
// RULE_10: Loader waits for cycle end before rewriting
// RULE_11: Reserved bits read zero and ignore writes
package pmw_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_WRITE_VALUE = 12'h0A4;
    localparam logic [11:0] OFS_CYCLE_CONTROL = 12'h0A8;
    localparam int unsigned DATA_MSB = 15;
    localparam int unsigned PHY_ADDR_MSB = 15;
    localparam int unsigned PHY_ADDR_LSB = 11;
    localparam int unsigned REG_IDX_MSB = 10;
    localparam int unsigned REG_IDX_LSB = 6;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [4:0] FIELD_RESET = 5'h00;
    localparam int unsigned FRAME_BITS = 32;
    localparam logic [5:0] BIT_CNT_RESET = 6'h00;
    localparam logic [1:0] MGMT_START = 2'h1;
    localparam logic [1:0] MGMT_WRITE_OP = 2'h1;
    localparam logic [1:0] MGMT_TURN = 2'h2;

    typedef enum logic [2:0] {
        PMW_IDLE = 3'h1,
        PMW_SHIFT = 3'h2,
        PMW_DONE = 3'h4
    } pmw_state_t;

    // Loader-side write strobe with address and data
    typedef struct packed {
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pmw_ldr_req_t;

    // Management serial outputs toward the PHYs
    typedef struct packed {
        logic mdc;
        logic mdio_o;
        logic mdio_oe;
    } pmw_mgmt_t;

    typedef struct packed {
        pmw_state_t st;
        logic [15:0] data;
        logic [4:0] phy_addr;
        logic [4:0] reg_idx;
        logic [31:0] frame;
        logic [5:0] bits_left;
        logic [7:0] div_cnt;
        logic busy;
        logic done;
        pmw_mgmt_t mgmt;
    } pmw_regs_t;
endpackage

/* pmw_phy_mgmt_write_port.sv */
// PHY management write port: loader-only register pair driving serial PHY write frames
`timescale 1ns/100ps
`default_nettype none
module pmw_phy_mgmt_write_port #(
    parameter int unsigned MDC_HALF = 2
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire pmw_pkg::pmw_ldr_req_t ldr_req,
    input wire logic host_wr,
    input wire logic [11:0] host_addr,
    output var pmw_pkg::pmw_mgmt_t mgmt,
    output logic busy,
    output logic cycle_done
);
    import pmw_pkg::*;

    pmw_regs_t r_q;
    pmw_regs_t r_d;
    logic [7:0] half_lim;

    assign half_lim = 8'(MDC_HALF - 1);

    // =====================================================
    // Next state
    always_comb
    begin
        r_d = r_q;
        r_d.done = 1'b0;
        // Host accesses are not decoded into state; host_unused only feeds a cover [RULE_01] [RULE_09]
        if (ldr_req.wr && ldr_req.addr == OFS_WRITE_VALUE)
        begin
            r_d.data = ldr_req.wdata[DATA_MSB:0]; // [RULE_02] [RULE_08] [RULE_11]
        end
        case (r_q.st)
            PMW_IDLE:
            begin
                r_d.mgmt.mdio_oe = 1'b0;
                r_d.mgmt.mdc = 1'b0;
                if (ldr_req.wr && ldr_req.addr == OFS_CYCLE_CONTROL)
                begin
                    r_d.phy_addr = ldr_req.wdata[PHY_ADDR_MSB:PHY_ADDR_LSB]; // [RULE_05]
                    r_d.reg_idx = ldr_req.wdata[REG_IDX_MSB:REG_IDX_LSB]; // [RULE_06]
                    // Frame uses data as held now [RULE_04]
                    r_d.frame = {MGMT_START, MGMT_WRITE_OP, ldr_req.wdata[PHY_ADDR_MSB:PHY_ADDR_LSB],
                        ldr_req.wdata[REG_IDX_MSB:REG_IDX_LSB], MGMT_TURN, r_q.data};
                    r_d.bits_left = 6'(FRAME_BITS);
                    r_d.div_cnt = 8'h00;
                    r_d.busy = 1'b1;
                    r_d.st = PMW_SHIFT;
                end
            end
            PMW_SHIFT:
            begin
                if (r_q.div_cnt == half_lim)
                begin
                    r_d.div_cnt = 8'h00;
                    r_d.mgmt.mdc = ~r_q.mgmt.mdc;
                    if (!r_q.mgmt.mdc)
                    begin
                        // Low-to-high: hold the current bit; the next bit is presented on the falling edge
                    end
                    else if (r_q.bits_left == BIT_CNT_RESET)
                    begin
                        r_d.st = PMW_DONE;
                    end
                    else
                    begin
                        r_d.mgmt.mdio_o = r_q.frame[FRAME_BITS-1];
                        r_d.mgmt.mdio_oe = 1'b1;
                        r_d.frame = {r_q.frame[FRAME_BITS-2:0], 1'b0};
                        r_d.bits_left = r_q.bits_left - 6'h01;
                    end
                end
                else
                begin
                    r_d.div_cnt = r_q.div_cnt + 8'h01;
                end
            end
            PMW_DONE:
            begin
                r_d.mgmt.mdio_oe = 1'b0;
                r_d.mgmt.mdc = 1'b0;
                r_d.busy = 1'b0;
                r_d.done = 1'b1;
                r_d.st = PMW_IDLE;
            end
            default:
            begin
                r_d.st = PMW_IDLE;
            end
        endcase
    end

    // =====================================================
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            r_q <= '0;
            r_q.st <= PMW_IDLE;
            r_q.data <= DATA_RESET;
            r_q.phy_addr <= FIELD_RESET;
            r_q.reg_idx <= FIELD_RESET;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign mgmt = r_q.mgmt;
    assign busy = r_q.busy;
    assign cycle_done = r_q.done;

    // =====================================================
    // Assertions
    logic host_unused;
    assign host_unused = host_wr & (host_addr == OFS_WRITE_VALUE);

    property p_host_ignored;
        @(posedge ref_clk) disable iff (srst)
        (host_wr && !ldr_req.wr) |=> (r_q.data == $past(r_q.data));
    endproperty
    a_host_ignored: assert property (p_host_ignored) else $error("host write changed data"); // [RULE_01]

    property p_data_load;
        @(posedge ref_clk) disable iff (srst)
        (ldr_req.wr && ldr_req.addr == OFS_WRITE_VALUE) |=> (r_q.data == $past(ldr_req.wdata[DATA_MSB:0]));
    endproperty
    a_data_load: assert property (p_data_load) else $error("data not loaded"); // [RULE_02]

    property p_launch;
        @(posedge ref_clk) disable iff (srst)
        (r_q.st == PMW_IDLE && ldr_req.wr && ldr_req.addr == OFS_CYCLE_CONTROL) |=>
            (busy && !mgmt.mdc && !mgmt.mdio_oe);
    endproperty
    a_launch: assert property (p_launch) else $error("control write did not launch"); // [RULE_04]

    property p_fields;
        @(posedge ref_clk) disable iff (srst)
        (r_q.st == PMW_IDLE && ldr_req.wr && ldr_req.addr == OFS_CYCLE_CONTROL) |=>
            (r_q.phy_addr == $past(ldr_req.wdata[PHY_ADDR_MSB:PHY_ADDR_LSB])
            && r_q.reg_idx == $past(ldr_req.wdata[REG_IDX_MSB:REG_IDX_LSB]));
    endproperty
    a_fields: assert property (p_fields) else $error("address fields wrong"); // [RULE_05] [RULE_06]

    property p_no_other_offset;
        @(posedge ref_clk) disable iff (srst)
        (r_q.st == PMW_IDLE && !(ldr_req.wr && ldr_req.addr == OFS_CYCLE_CONTROL)) |=> !busy;
    endproperty
    a_no_other_offset: assert property (p_no_other_offset) else $error("cycle without control write"); // [RULE_08]

    property p_done_ends;
        @(posedge ref_clk) disable iff (srst)
        cycle_done |-> (!busy && !mgmt.mdio_oe);
    endproperty
    a_done_ends: assert property (p_done_ends) else $error("done while busy"); // [RULE_09]

    property p_idle_quiet;
        @(posedge ref_clk) disable iff (srst)
        (!busy) |-> (!mgmt.mdio_oe && !mgmt.mdc);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("bus active while idle"); // [RULE_11]

    property p_done_pulse;
        @(posedge ref_clk) disable iff (srst)
        cycle_done |=> !cycle_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle"); // [RULE_04]

    // =====================================================
    // Frame shape, refused-launch and data-hold checks
    property p_launch_count;
        @(posedge ref_clk) disable iff (srst)
        (r_q.st == PMW_IDLE && ldr_req.wr && ldr_req.addr == OFS_CYCLE_CONTROL) |=>
            (r_q.st == PMW_SHIFT && r_q.bits_left == 6'(FRAME_BITS));
    endproperty
    a_launch_count: assert property (p_launch_count) else $error("frame not armed"); // [RULE_04]

    property p_oe_in_frame;
        @(posedge ref_clk) disable iff (srst)
        mgmt.mdio_oe |-> busy;
    endproperty
    a_oe_in_frame: assert property (p_oe_in_frame) else $error("data pin driven outside frame"); // [RULE_04]

    property p_first_bit;
        @(posedge ref_clk) disable iff (srst)
        $rose(mgmt.mdio_oe) |-> (!mgmt.mdio_o && !mgmt.mdc);
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("frame start bit wrong"); // [RULE_04]

    property p_bit_on_fall;
        @(posedge ref_clk) disable iff (srst)
        (busy && $changed(mgmt.mdio_o)) |-> $fell(mgmt.mdc);
    endproperty
    a_bit_on_fall: assert property (p_bit_on_fall) else $error("data moved off falling clock"); // [RULE_04]

    property p_all_bits_sent;
        @(posedge ref_clk) disable iff (srst)
        cycle_done |-> (r_q.bits_left == BIT_CNT_RESET);
    endproperty
    a_all_bits_sent: assert property (p_all_bits_sent) else $error("frame ended early"); // [RULE_04]

    property p_done_after_busy;
        @(posedge ref_clk) disable iff (srst)
        $fell(busy) |-> cycle_done;
    endproperty
    a_done_after_busy: assert property (p_done_after_busy) else $error("frame end not flagged"); // [RULE_04]

    property p_refused_launch;
        @(posedge ref_clk) disable iff (srst)
        (busy && ldr_req.wr && ldr_req.addr == OFS_CYCLE_CONTROL) |=>
            (r_q.phy_addr == $past(r_q.phy_addr) && r_q.reg_idx == $past(r_q.reg_idx));
    endproperty
    a_refused_launch: assert property (p_refused_launch) else $error("control taken while busy"); // [RULE_05] [RULE_06]

    property p_data_kept;
        @(posedge ref_clk) disable iff (srst)
        !(ldr_req.wr && ldr_req.addr == OFS_WRITE_VALUE) |=> (r_q.data == $past(r_q.data));
    endproperty
    a_data_kept: assert property (p_data_kept) else $error("data changed without data write"); // [RULE_02]

    c_launch: cover property (@(posedge ref_clk) disable iff (srst) $rose(busy));
    c_done: cover property (@(posedge ref_clk) disable iff (srst) cycle_done);
    c_host: cover property (@(posedge ref_clk) disable iff (srst) host_unused);
    c_refused: cover property (@(posedge ref_clk) disable iff (srst) busy && ldr_req.wr && ldr_req.addr == OFS_CYCLE_CONTROL);
endmodule
`default_nettype wire

/* pmw_phy_model.sv */
// Behavioural PHY that captures management write frames
`timescale 1ns/100ps
`default_nettype none
module pmw_phy_model
(
    input wire logic ref_clk,
    input wire pmw_pkg::pmw_mgmt_t mgmt,
    output logic [31:0] frame_q,
    output logic [5:0] count_q
);
    import pmw_pkg::*;
    logic mdc_q;
    logic oe_q;
    // ==========================================
    // Capture
    // Data is taken on rising mdc; a new frame starts when the driver enables
    always_ff @(posedge ref_clk)
    begin
        mdc_q <= mgmt.mdc;
        oe_q <= mgmt.mdio_oe;
        if (mgmt.mdio_oe && !oe_q)
            count_q <= 6'h00;
        else if (mgmt.mdio_oe && mgmt.mdc && !mdc_q)
        begin
            frame_q <= {frame_q[30:0], mgmt.mdio_o};
            count_q <= count_q + 6'h01;
        end
    end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the PHY management write port
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pmw_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    pmw_ldr_req_t ldr_req = '0;
    logic host_wr = 1'b0;
    logic [11:0] host_addr = 12'h000;
    pmw_mgmt_t mgmt;
    logic busy;
    logic cycle_done;
    logic [31:0] frame_q;
    logic [5:0] count_q;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    always #10 ref_clk = ~ref_clk;
    pmw_phy_mgmt_write_port #(.MDC_HALF(1)) pmw_phy_mgmt_write_port_i (.ref_clk(ref_clk), .srst(srst),
        .ldr_req(ldr_req), .host_wr(host_wr), .host_addr(host_addr), .mgmt(mgmt), .busy(busy),
        .cycle_done(cycle_done));
    pmw_phy_model pmw_phy_model_i (.ref_clk(ref_clk), .mgmt(mgmt), .frame_q(frame_q), .count_q(count_q));
    // ==========================================
    // Shared tasks
    task automatic report_and_stop();
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic ldr_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        ldr_req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        ldr_req.wr <= 1'b0;
    endtask
    task automatic frame_chk(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
        int n;
        n = 0;
        while (cycle_done !== 1'b1 && n < 300)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk({31'h0, cycle_done}, 32'h1, "done seen");
        chk({26'h0, count_q}, 32'h20, "bit count");
        chk(frame_q, {4'h5, p, r, 2'h2, d}, "frame");
        @(posedge ref_clk);
        #1;
        chk({30'h0, busy, cycle_done}, 32'h0, "done pulse");
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        chk({29'h0, busy, mgmt.mdc, mgmt.mdio_oe}, 32'h0, "idle outputs");
        ldr_wr(OFS_CYCLE_CONTROL, 32'h0000F802);
        frame_chk(5'h1F, 5'h00, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_fields();
        ldr_wr(OFS_WRITE_VALUE, 32'hFFFFA5C3);
        ldr_wr(OFS_CYCLE_CONTROL, 32'hFFFF07FF);
        frame_chk(5'h00, 5'h1F, 16'hA5C3);
        $display("t_fields done");
    endtask
    task automatic t_host();
        @(posedge ref_clk);
        host_wr <= 1'b1;
        host_addr <= OFS_WRITE_VALUE;
        repeat (2) @(posedge ref_clk);
        host_addr <= OFS_CYCLE_CONTROL;
        repeat (2) @(posedge ref_clk);
        host_wr <= 1'b0;
        #1;
        chk({31'h0, busy}, 32'h0, "host launch");
        ldr_wr(OFS_CYCLE_CONTROL, 32'h00000842);
        frame_chk(5'h01, 5'h01, 16'hA5C3);
        $display("t_host done");
    endtask
    task automatic t_busy();
        ldr_wr(OFS_WRITE_VALUE, 32'h00001234);
        ldr_wr(OFS_CYCLE_CONTROL, 32'h00005542);
        ldr_wr(OFS_WRITE_VALUE, 32'h00005678);
        ldr_wr(OFS_CYCLE_CONTROL, 32'h000018C2);
        frame_chk(5'h0A, 5'h15, 16'h1234);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({31'h0, busy}, 32'h0, "ignored launch");
        ldr_wr(OFS_CYCLE_CONTROL, 32'h000018C2);
        frame_chk(5'h03, 5'h03, 16'h5678);
        $display("t_busy done");
    endtask
    task automatic t_midreset();
        ldr_wr(OFS_WRITE_VALUE, 32'h0000BEEF);
        ldr_wr(OFS_CYCLE_CONTROL, 32'h00002882);
        repeat (10) @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({29'h0, busy, mgmt.mdc, mgmt.mdio_oe}, 32'h0, "reset mid-frame");
        ldr_wr(OFS_CYCLE_CONTROL, 32'h00002882);
        frame_chk(5'h05, 5'h02, 16'h0000);
        $display("t_midreset done");
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            report_and_stop();
        end
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_fields();
        t_host();
        t_busy();
        t_midreset();
        report_and_stop();
    end
endmodule
`default_nettype wire
